// ===== rtl/lpc_buf2.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset, clock enable
// Notes: read data come from a register; full and empty are exact
`timescale 1ns/100ps
module lpc_buf2 #(
	parameter W = 20
) (
	// clock and reset
	input wire mclk,
	input wire reset,
	input wire ce,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output reg [W-1:0] out_data_reg
);
	reg [W-1:0] hold_reg;
	reg [1:0] count_reg;
	wire push;
	wire pop;

	assign in_ready = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// head lives in out_data_reg, second entry in hold_reg
	always @(posedge mclk) begin
		if (reset) begin
			count_reg <= 2'h0;
			hold_reg <= {W{1'b0}};
			out_data_reg <= {W{1'b0}};
		end else if (ce) begin
			case ({push, pop})
			2'b10: begin
				if (count_reg == 2'h0)
					out_data_reg <= in_data;
				else
					hold_reg <= in_data;
				count_reg <= count_reg + 2'h1;
			end
			2'b01: begin
				out_data_reg <= hold_reg;
				count_reg <= count_reg - 2'h1;
			end
			2'b11: begin
				if (count_reg == 2'h1)
					out_data_reg <= in_data;
				else begin
					out_data_reg <= hold_reg;
					hold_reg <= in_data;
				end
			end
			default: begin
				count_reg <= count_reg;
			end
			endcase
		end
	end
endmodule // lpc_buf2

// ===== rtl/lpc_consts.vh
// Purpose: shared constants for the low-power dram pin capture block
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef LPC_CONSTS_VH
`define LPC_CONSTS_VH

`define LPC_CA_W 7
`define LPC_CMD_W 14
`define LPC_DQ_W 16
`define LPC_BYTES 2
`define LPC_WORD_W 20
`define LPC_PAR_LSB 18
`define LPC_DMI_LSB 16
`define LPC_SYNC_W 35
`define LPC_DMI_MASK 2'h0
`define LPC_DMI_DBI 2'h1
`define LPC_DMI_RDPAR 2'h2
`define LPC_DBI_LIMIT 4'h4
`define LPC_EXT_RATE_MBPS 4267
`define LPC_NORMAL_RATE_MBPS 3200

`endif

// ===== rtl/lpc_pin_capture.v
// Purpose: pin-level command, clock and data capture for one dram channel
// Assumes: all pins are sampled by mclk (250 MHz) through two flip-flops
// Notes: the link clocks are oversampled; edges are found from the samples
`timescale 1ns/100ps
`include "lpc_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module lpc_pin_capture (
	// clock, reset, enable
	input wire mclk,
	input wire reset,
	input wire ce,
	// die reset pin
	input wire reset_pin_n,
	output wire die_reset,
	// command clock, selects, command/address
	input wire ck_t,
	input wire ck_c,
	input wire cs0,
	input wire cs1,
	input wire [`LPC_CA_W-1:0] ca,
	// data clocks
	input wire [`LPC_BYTES-1:0] wck_t,
	input wire [`LPC_BYTES-1:0] wck_c,
	// data bus
	input wire [`LPC_DQ_W-1:0] dq_i,
	output reg [`LPC_DQ_W-1:0] dq_o_reg,
	output reg dq_oe_reg,
	// read strobes
	input wire [`LPC_BYTES-1:0] rdqs_t_i,
	output reg [`LPC_BYTES-1:0] rdqs_t_o_reg,
	output reg [`LPC_BYTES-1:0] rdqs_c_o_reg,
	output reg rdqs_oe_reg,
	// mask/inversion lines
	input wire [`LPC_BYTES-1:0] dmi_i,
	output reg [`LPC_BYTES-1:0] dmi_o_reg,
	output reg dmi_oe_reg,
	// configuration
	input wire rank_is_one,
	input wire dual_rank_pkg,
	input wire low_power_state,
	input wire wr_link_prot_en,
	input wire [1:0] dmi_mode,
	input wire sixteen_bank_mode,
	input wire ratio_2to1,
	input wire link_ecc_en,
	input wire dvfs_en,
	input wire wr_active,
	input wire rd_active,
	// command out
	output reg [`LPC_CMD_W-1:0] cmd_word_reg,
	output reg cmd_valid_reg,
	output reg lp_exit_reg,
	output wire ext_rate_ok,
	// write data out
	output wire wr_valid,
	input wire wr_ready,
	output wire [`LPC_WORD_W-1:0] wr_word,
	output wire wr_buf_ready,
	// read data in
	input wire rd_valid,
	output wire rd_ready,
	input wire [`LPC_DQ_W-1:0] rd_data
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	wire [`LPC_SYNC_W-1:0] pin_raw;
	reg [`LPC_SYNC_W-1:0] meta_reg;
	reg [`LPC_SYNC_W-1:0] sync_reg;
	reg rst_meta_reg;
	reg rst_sync_reg;
	wire rst_int;
	assign pin_raw = {rdqs_t_i, dmi_i, dq_i, wck_c, wck_t, ca, cs1, cs0, ck_c, ck_t};
	wire ck_t_s;
	wire ck_c_s;
	wire cs0_s;
	wire cs1_s;
	wire [`LPC_CA_W-1:0] ca_s;
	wire [`LPC_BYTES-1:0] wck_t_s;
	wire [`LPC_BYTES-1:0] wck_c_s;
	wire [`LPC_DQ_W-1:0] dq_s;
	wire [`LPC_BYTES-1:0] dmi_s;
	wire [`LPC_BYTES-1:0] par_s;
	wire ck_s;
	wire [`LPC_BYTES-1:0] wck_s;
	// unpacked in the same order as pin_raw, so no field offsets are spelled out
	assign {par_s, dmi_s, dq_s, wck_c_s, wck_t_s, ca_s, cs1_s, cs0_s, ck_c_s, ck_t_s} = sync_reg;
	assign ck_s = ck_t_s & ~ck_c_s;
	assign wck_s = wck_t_s & ~wck_c_s;

	// the die reset output follows the pin with no clock involved
	assign die_reset = ~reset_pin_n;
	assign rst_int = reset | rst_sync_reg;

	always @(posedge mclk) begin
		if (ce) begin
			meta_reg <= pin_raw;
			sync_reg <= meta_reg;
			rst_meta_reg <= ~reset_pin_n;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command clock crossings and command capture
	reg ck_prev_reg;
	reg [`LPC_BYTES-1:0] wck_prev_reg;
	reg [`LPC_CA_W-1:0] ca_first_reg;
	reg cs_hit_reg;
	reg cs_lvl_reg;
	wire ck_rise = ck_s & ~ck_prev_reg;
	wire ck_fall = ~ck_s & ck_prev_reg;
	wire [`LPC_BYTES-1:0] wck_rise = wck_s & ~wck_prev_reg;
	// single-rank packages leave rank-1 select unconnected, so it is ignored
	wire cs_mine = rank_is_one ? (cs1_s & dual_rank_pkg) : cs0_s;

	// only sixteen-bank mode at the 2:1 ratio with ecc and dvfs off may exceed the normal rate
	assign ext_rate_ok = sixteen_bank_mode & ratio_2to1 & ~link_ecc_en & ~dvfs_en;

	always @(posedge mclk) begin
		if (rst_int) begin
			ck_prev_reg <= 1'b0;
			wck_prev_reg <= {`LPC_BYTES{1'b0}};
			ca_first_reg <= {`LPC_CA_W{1'b0}};
			cs_hit_reg <= 1'b0;
			cs_lvl_reg <= 1'b0;
			cmd_word_reg <= {`LPC_CMD_W{1'b0}};
			cmd_valid_reg <= 1'b0;
			lp_exit_reg <= 1'b0;
		end else if (ce) begin
			ck_prev_reg <= ck_s;
			wck_prev_reg <= wck_s;
			cs_lvl_reg <= cs_mine;
			cmd_valid_reg <= 1'b0;
			lp_exit_reg <= 1'b0;
			if (low_power_state) begin
				// select acts as a level here; no clock crossing needed
				cs_hit_reg <= 1'b0;
				lp_exit_reg <= cs_mine & ~cs_lvl_reg;
			end else begin
				if (ck_rise) begin
					ca_first_reg <= ca_s;
					cs_hit_reg <= cs_mine;
				end
				if (ck_fall && cs_hit_reg) begin
					cmd_word_reg <= {ca_first_reg, ca_s};
					cmd_valid_reg <= 1'b1;
					cs_hit_reg <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write capture, one lane per byte on its own data clock
	wire [`LPC_DQ_W-1:0] wbyte;
	wire [`LPC_BYTES-1:0] wdmi;
	wire [`LPC_BYTES-1:0] wpar;
	wire [`LPC_BYTES-1:0] wgot;
	wire both_got = &wgot;
	wire push = both_got & wr_buf_ready;
	genvar b;
	generate
		for (b = 0; b < `LPC_BYTES; b = b + 1) begin : g_wlane
			// each lane owns its flops, so every register has a single driver
			reg [7:0] byte_reg;
			reg mask_reg;
			reg par_reg;
			reg got_reg;
			wire [7:0] lane = dq_s[8*b+7:8*b];
			// bus inversion restores the true byte when flagged
			wire inv = (dmi_mode == `LPC_DMI_DBI) & dmi_s[b];
			assign wbyte[8*b+7:8*b] = byte_reg;
			assign wdmi[b] = mask_reg;
			assign wpar[b] = par_reg;
			assign wgot[b] = got_reg;
			always @(posedge mclk) begin
				if (rst_int) begin
					byte_reg <= 8'h00;
					mask_reg <= 1'b0;
					par_reg <= 1'b0;
					got_reg <= 1'b0;
				end else if (ce) begin
					if (wr_active && wck_rise[b] && !got_reg) begin
						byte_reg <= inv ? ~lane : lane;
						mask_reg <= (dmi_mode == `LPC_DMI_MASK) & dmi_s[b];
						par_reg <= wr_link_prot_en & par_s[b];
						got_reg <= 1'b1;
					end else if (push) begin
						got_reg <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// a stalled receiver fills the buffer; further write bytes then hold
	lpc_buf2 #(
		.W(`LPC_WORD_W)
	) u_wbuf (
		.mclk(mclk),
		.reset(rst_int),
		.ce(ce),
		.in_valid(both_got),
		.in_ready(wr_buf_ready),
		.in_data({wpar, wdmi, wbyte}),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data_reg(wr_word)
	);

	////////////////////////////////////////////////////////////////////////////
	// read drive, paced by data clock 0
	assign rd_ready = rd_active & wck_rise[0];
	wire [`LPC_BYTES-1:0] dbi_flag;
	wire [`LPC_BYTES-1:0] rd_par;
	wire [`LPC_DQ_W-1:0] rd_out;
	generate
		for (b = 0; b < `LPC_BYTES; b = b + 1) begin : g_rlane
			wire [7:0] lane = rd_data[8*b+7:8*b];
			wire [3:0] ones = lane[0] + lane[1] + lane[2] + lane[3]
				+ lane[4] + lane[5] + lane[6] + lane[7];
			assign dbi_flag[b] = (dmi_mode == `LPC_DMI_DBI) & (ones > `LPC_DBI_LIMIT);
			assign rd_par[b] = ^lane;
			assign rd_out[8*b+7:8*b] = dbi_flag[b] ? ~lane : lane;
		end
	endgenerate

	always @(posedge mclk) begin
		if (rst_int) begin
			dq_o_reg <= {`LPC_DQ_W{1'b0}};
			dq_oe_reg <= 1'b0;
			rdqs_t_o_reg <= {`LPC_BYTES{1'b0}};
			rdqs_c_o_reg <= {`LPC_BYTES{1'b1}};
			rdqs_oe_reg <= 1'b0;
			dmi_o_reg <= {`LPC_BYTES{1'b0}};
			dmi_oe_reg <= 1'b0;
		end else if (ce) begin
			dq_oe_reg <= rd_active;
			dmi_oe_reg <= rd_active;
			// strobe true leg is an input while writes carry parity
			rdqs_oe_reg <= rd_active & ~(wr_active & wr_link_prot_en);
			if (!rd_active) begin
				rdqs_t_o_reg <= {`LPC_BYTES{1'b0}};
				rdqs_c_o_reg <= {`LPC_BYTES{1'b1}};
			end else if (rd_ready && rd_valid) begin
				dq_o_reg <= rd_out;
				rdqs_t_o_reg <= ~rdqs_t_o_reg;
				rdqs_c_o_reg <= rdqs_t_o_reg;
				if (dmi_mode == `LPC_DMI_RDPAR)
					dmi_o_reg <= rd_par;
				else
					dmi_o_reg <= dbi_flag;
			end
		end
	end
endmodule // lpc_pin_capture

// ===== sim/lpc_ctrl_model.sv
// Purpose: controller side clocks for the pin capture block
// Assumes: run is raised once by the bench after reset and left high
// Notes: offset from mclk so edges never line up with sampling
`timescale 1ns/100ps
module lpc_ctrl_model (
	// control
	input wire run,
	// clocks to the device
	output reg ck_t,
	output wire ck_c,
	output reg [1:0] wck_t,
	output wire [1:0] wck_c
);
	initial begin
		ck_t = 1'b0;
		wck_t = 2'h0;
		#0.7;
		// clocks park low when idle; data clocks run at twice the command clock
		forever begin
			#16;
			wck_t = {2{run}} & ~wck_t;
			#16;
			wck_t = {2{run}} & ~wck_t;
			ck_t = run & ~ck_t;
		end
	end
	assign ck_c = ~ck_t;
	assign wck_c = ~wck_t;
endmodule // lpc_ctrl_model

// ===== sim/lpc_pin_capture_asserts.sv
// Purpose: concurrent checks on the pin capture block ports
// Assumes: ce held high by the bench
// Notes: bound into the design by the statement at the foot
`timescale 1ns/100ps
module lpc_pin_capture_asserts (
	// clock and resets
	input wire mclk,
	input wire reset,
	input wire reset_pin_n,
	input wire die_reset,
	// command side
	input wire ck_t,
	input wire low_power_state,
	input wire cmd_valid_reg,
	input wire lp_exit_reg,
	// data side
	input wire rd_active,
	input wire dq_oe_reg,
	input wire dmi_oe_reg,
	input wire [1:0] rdqs_t_o_reg,
	input wire [1:0] rdqs_c_o_reg,
	input wire wr_valid,
	input wire wr_ready,
	input wire [19:0] wr_word
);
	default clocking cb @(posedge mclk); endclocking
	// the die reset pin also clears the block, a few cycles after the pin
	default disable iff (reset || die_reset);
	sequence s_wr_stall;
		wr_valid && !wr_ready;
	endsequence
	sequence s_lp_pulse;
		$past(low_power_state) ##1 !lp_exit_reg;
	endsequence
	a_die_reset:
		assert property (disable iff (reset) die_reset == !reset_pin_n)
			else $error("die reset wrong");
	a_rst_quiet:
		assert property ($fell(reset) |-> !cmd_valid_reg && !dq_oe_reg && !wr_valid)
			else $error("outputs active after reset");
	a_cmd_single:
		assert property (cmd_valid_reg |=> !cmd_valid_reg [*5]) else $error("command too soon");
	a_cmd_fall:
		assert property (cmd_valid_reg |-> !ck_t && !$past(ck_t, 2)) else $error("command early");
	// a command already past its falling crossing may still land just after entry
	a_no_cmd_lp:
		assert property (low_power_state && $past(low_power_state, 6) |-> !cmd_valid_reg)
			else $error("command in low power");
	a_lp_exit:
		assert property (lp_exit_reg |-> s_lp_pulse) else $error("bad low power exit");
	a_oe_follow:
		assert property (dq_oe_reg == $past(rd_active) && dmi_oe_reg == dq_oe_reg)
			else $error("output enable wrong");
	a_rdqs_diff:
		assert property (rdqs_c_o_reg == ~rdqs_t_o_reg)
			else $error("strobe legs not complementary");
	a_wr_hold:
		assert property (s_wr_stall |=> wr_valid && $stable(wr_word)) else $error("word lost");
endmodule // lpc_pin_capture_asserts
////////////////////////////////////////
bind lpc_pin_capture lpc_pin_capture_asserts i_chk (
	.mclk(mclk), .reset(reset), .reset_pin_n(reset_pin_n), .die_reset(die_reset),
	.ck_t(ck_t), .low_power_state(low_power_state), .cmd_valid_reg(cmd_valid_reg),
	.lp_exit_reg(lp_exit_reg), .rd_active(rd_active), .dq_oe_reg(dq_oe_reg),
	.dmi_oe_reg(dmi_oe_reg), .rdqs_t_o_reg(rdqs_t_o_reg), .rdqs_c_o_reg(rdqs_c_o_reg),
	.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word)
);

// ===== sim/lpc_pin_capture_bench.sv
// Purpose: self-checking bench for the pin capture block
// Assumes: inputs change on falling mclk
// Notes: commands, writes with stall, reads, die reset
`timescale 1ns/100ps
module lpc_pin_capture_bench;
	logic mclk, reset, ce, reset_pin_n, cs0, cs1, run, rank_is_one, dual_rank_pkg;
	logic low_power_state, wr_link_prot_en, sixteen_bank_mode, ratio_2to1, link_ecc_en;
	logic dvfs_en, wr_active, rd_active, wr_ready, rd_valid, ck_t, ck_c, die_reset;
	logic dq_oe_reg, rdqs_oe_reg, dmi_oe_reg, cmd_valid_reg, lp_exit_reg, ext_rate_ok;
	logic wr_valid, wr_buf_ready, rd_ready;
	logic [1:0] wck_t, wck_c, rdqs_t_i, dmi_i, dmi_mode, rdqs_t_o_reg, rdqs_c_o_reg, dmi_o_reg;
	logic [6:0] ca;
	logic [13:0] cmd_word_reg;
	logic [15:0] dq_i, dq_o_reg, rd_data;
	logic [19:0] wr_word;
	int failures = 0, total_checks = 0, lp_seen = 0;
	lpc_pin_capture i_dut (
		.mclk(mclk), .reset(reset), .ce(ce), .reset_pin_n(reset_pin_n),
		.die_reset(die_reset), .ck_t(ck_t), .ck_c(ck_c), .cs0(cs0), .cs1(cs1), .ca(ca),
		.wck_t(wck_t), .wck_c(wck_c), .dq_i(dq_i), .dq_o_reg(dq_o_reg),
		.dq_oe_reg(dq_oe_reg), .rdqs_t_i(rdqs_t_i), .rdqs_t_o_reg(rdqs_t_o_reg),
		.rdqs_c_o_reg(rdqs_c_o_reg), .rdqs_oe_reg(rdqs_oe_reg), .dmi_i(dmi_i),
		.dmi_o_reg(dmi_o_reg), .dmi_oe_reg(dmi_oe_reg), .rank_is_one(rank_is_one),
		.dual_rank_pkg(dual_rank_pkg), .low_power_state(low_power_state),
		.wr_link_prot_en(wr_link_prot_en), .dmi_mode(dmi_mode),
		.sixteen_bank_mode(sixteen_bank_mode), .ratio_2to1(ratio_2to1),
		.link_ecc_en(link_ecc_en), .dvfs_en(dvfs_en), .wr_active(wr_active),
		.rd_active(rd_active), .cmd_word_reg(cmd_word_reg), .cmd_valid_reg(cmd_valid_reg),
		.lp_exit_reg(lp_exit_reg), .ext_rate_ok(ext_rate_ok), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_word(wr_word), .wr_buf_ready(wr_buf_ready),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data)
	);
	lpc_ctrl_model i_ctrl (.run(run), .ck_t(ck_t), .ck_c(ck_c), .wck_t(wck_t), .wck_c(wck_c));
	always #2 mclk = ~mclk;
	always @(negedge mclk) if (lp_exit_reg === 1'b1) lp_seen++;
	////////////////////////////////////////
	task chk(input [31:0] e, g, input string n);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task print_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// first half set while the clock is low, each half held well past the 2ff delay
	task send_cmd(input [1:0] sel, input e, input [6:0] a, b);
		int hit;
		{cs1, cs0} = 2'h0;
		@(negedge ck_t);
		@(negedge mclk);
		{cs1, cs0} = sel;
		ca = a;
		@(posedge ck_t);
		repeat (4) @(negedge mclk);
		ca = b;
		{cs1, cs0} = 2'h0;
		@(negedge ck_t);
		hit = 0;
		repeat (8) @(negedge mclk) hit += (cmd_valid_reg === 1'b1);
		chk(e, hit, "cmd_valid");
		if (e) chk({a, b}, cmd_word_reg, "cmd_word");
	endtask
	task wr_burst(input [1:0] m, input p);
		int i, pops;
		dmi_mode = m;
		wr_link_prot_en = p;
		{dq_i, dmi_i, rdqs_t_i} = {16'ha55a, 2'h1, 2'h2};
		// let the pins pass the synchronisers before the burst opens
		repeat (3) @(negedge mclk);
		wr_active = 1'b1;
		for (i = 0; i < 200 && wr_buf_ready !== 1'b0; i++) @(negedge mclk);
		wr_active = 1'b0;
		chk({1'b1, p ? 2'h2 : 2'h0, m[0] ? 16'ha5a5 : 16'ha55a},
			{wr_valid, wr_word[19:18], wr_word[15:0]}, "wr_word");
		if (!m[0]) chk(2'h1, wr_word[17:16], "wr_mask");
		wr_ready = 1'b1;
		pops = 0;
		// sample before each edge: every valid cycle under ready is one pop
		repeat (20) begin
			pops += (wr_valid === 1'b1);
			@(negedge mclk);
		end
		wr_ready = 1'b0;
		chk(2, pops, "wr_pops");
		chk(2'h1, {wr_valid, wr_buf_ready}, "wr_empty");
	endtask
	task rd_word(input [1:0] m, input [15:0] d, e, input [1:0] em);
		int i;
		logic [1:0] t;
		{dmi_mode, rd_data, rd_valid, rd_active} = {m, d, 2'h3};
		// one accepted word flips the true strobe leg once
		t = ~rdqs_t_o_reg;
		for (i = 0; i < 40 && rd_ready !== 1'b1; i++) @(negedge mclk);
		@(negedge mclk);
		rd_valid = 1'b0;
		@(negedge mclk);
		chk({e, em, 2'h3}, {dq_o_reg, dmi_o_reg, dq_oe_reg, rdqs_oe_reg}, "rd_out");
		chk(t, rdqs_t_o_reg, "rdqs_t");
		rd_active = 1'b0;
		@(negedge mclk);
	endtask
	initial begin
		mclk = 1'b0;
		{cs0, cs1, run, rank_is_one, dual_rank_pkg, low_power_state, wr_link_prot_en} = '0;
		{wr_active, rd_active, wr_ready, rd_valid, link_ecc_en, dvfs_en} = '0;
		{reset, ce, reset_pin_n, sixteen_bank_mode, ratio_2to1} = '1; // rate set once
		{ca, dq_i, rd_data, rdqs_t_i, dmi_i, dmi_mode} = '0;
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		chk(3'h3, {dq_oe_reg, rdqs_c_o_reg}, "rst_out");
		chk(2'h1, {wr_valid, wr_buf_ready}, "rst_buf");
		chk(1, ext_rate_ok, "ext_rate_ok");
		dvfs_en = 1'b1;
		@(negedge mclk);
		chk(0, ext_rate_ok, "ext_rate_dvfs");
		dvfs_en = 1'b0;
		run = 1'b1;
		$display("test reset done");
		send_cmd(2'h1, 1'b1, 7'h15, 7'h6a);
		send_cmd(2'h2, 1'b0, 7'h7f, 7'h00);
		send_cmd(2'h0, 1'b0, 7'h01, 7'h02);
		{rank_is_one, dual_rank_pkg} = 2'h3;
		send_cmd(2'h2, 1'b1, 7'h40, 7'h3f);
		low_power_state = 1'b1;
		send_cmd(2'h2, 1'b0, 7'h33, 7'h4c);
		chk(1, lp_seen, "lp_exit");
		low_power_state = 1'b0;
		$display("test command done");
		wr_burst(2'h0, 1'b0);
		wr_burst(2'h1, 1'b1);
		$display("test write done");
		rd_word(2'h2, 16'h0301, 16'h0301, 2'h1);
		rd_word(2'h1, 16'h00ff, 16'h0000, 2'h1);
		$display("test read done");
		rd_active = 1'b1;
		repeat (2) @(negedge mclk);
		chk(2'h3, {dq_oe_reg, rdqs_oe_reg}, "pre_rst_oe");
		reset_pin_n = 1'b0;
		#1;
		chk(1, die_reset, "die_reset");
		repeat (4) @(negedge mclk);
		chk(4'h3, {dq_oe_reg, rdqs_oe_reg, rdqs_c_o_reg}, "pin_rst_out");
		rd_active = 1'b0;
		repeat (2) @(negedge mclk);
		reset_pin_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk(2'h1, {wr_valid, wr_buf_ready}, "pin_rst_buf");
		$display("test die reset done");
		print_verdict;
	end
	initial begin
		#20000;
		failures++;
		print_verdict;
	end
endmodule // lpc_pin_capture_bench
